// ### design/spmm_pkg.sv
// Purpose: Constants for the switch power mode manager
// Assumes: Registers are 8 bits wide, reached by an 8-bit register number
// Notes:   Go-sleep unit and beacon timing are held here as cycle counts
`default_nettype none
package spmm_pkg;
    // Register numbers
    localparam logic [7:0] ADDR_PWR_MODE   = 8'h0e;
    localparam logic [7:0] ADDR_GO_SLEEP   = 8'h0f;
    localparam logic [7:0] ADDR_PORT_CTL_A = 8'h1d;
    localparam logic [7:0] ADDR_PORT_CTL_B = 8'h2d;
    localparam logic [7:0] ADDR_PORT_CTL_C = 8'h3d;
    localparam logic [7:0] ADDR_PORT_CTL_D = 8'h4d;
    // Field positions
    localparam int MODE_LSB     = 3;
    localparam int PORT_PD_BIT  = 3;
    localparam int MII_PD_BIT   = 11;
    // Reset values
    localparam logic [7:0] RST_PWR_MODE = 8'h00;
    localparam logic [7:0] RST_GO_SLEEP = 8'h00;
    localparam logic [7:0] RST_PORT_CTL = 8'h00;
    // Mode encodings
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_EDETECT = 2'h1;
    localparam logic [1:0] MODE_SOFTPD  = 2'h2;
    // Timing at 125 MHz
    localparam int CLK_MHZ        = 125;
    localparam int PULSE_NS       = 120;
    localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int BEACON_MS      = 1000;
    localparam int BEACON_CYC     = BEACON_MS * CLK_MHZ * 1000;
    localparam int SLEEP_UNIT_MS  = 1;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * CLK_MHZ * 1000;
    // Energy-detect sub-state
    typedef enum logic {ED_AWAKE, ED_ASLEEP} spmm_ed_t;
endpackage
`default_nettype wire

// ### design/spmm_top.sv
// Purpose: Power mode sequencer for a five-port switch
// Assumes: Host register access arrives as a one-cycle strobe on CLK_I
// Notes:   Enable outputs are active high; internal reset is a pulse
`timescale 1ns/1ps
`default_nettype none
module spmm_top #(
    parameter int NPORT      = 4,
    parameter int BEACON_CYC = spmm_pkg::BEACON_CYC,
    parameter int UNIT_CYC   = spmm_pkg::SLEEP_UNIT_CYC
) (
    input  wire logic             CLK_I,        // Core clock
    input  wire logic             RSTN_I,       // Async reset, low
    input  wire logic             REG_WR_I,     // Register write strobe
    input  wire logic             REG_RD_I,     // Register read strobe
    input  wire logic [7:0]       REG_ADDR_I,   // Register number
    input  wire logic [7:0]       REG_WDATA_I,  // Write data
    output logic      [7:0]       REG_RDATA_O,  // Read data
    input  wire logic             ENERGY_I,     // Cable energy, async pin
    input  wire logic             LINK_UP_I,    // Cable attached, async pin
    input  wire logic [NPORT-1:0] MII_PD_I,     // PHY ctrl reg 0 bit 11 per port
    output logic                  PLL_EN_O,     // PLL clocks running
    output logic                  PHY_EN_O,     // PHYs fully powered
    output logic                  MAC_EN_O,     // MACs powered
    output logic                  HOST_EN_O,    // Host interface usable
    output logic                  RX_DET_EN_O,  // Receiver energy detect on
    output logic                  BEACON_O,     // Line pulse
    output logic [NPORT-1:0]      PORT_PD_O,    // Per-port PHY power-down
    output logic                  INT_RST_O     // Internal reset pulse
);
    // Pin synchronisers; first stage read only by second
    logic [1:0] en_s1_q, en_s2_q;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            en_s1_q <= 2'h0;
            en_s2_q <= 2'h0;
        end else begin
            en_s1_q <= {LINK_UP_I, ENERGY_I};
            en_s2_q <= en_s1_q;
        end
    end
    logic energy, link_up;
    assign energy  = en_s2_q[0];
    assign link_up = en_s2_q[1];

    // Register state
    logic [7:0]       mode_reg_q, mode_reg_d;   // Power mode control
    logic [7:0]       sleep_q, sleep_d;         // Go-sleep time
    logic [7:0]       pctl_q [NPORT], pctl_d [NPORT]; // Port control copies
    logic [1:0]       mode;                     // Decoded mode field
    logic             soft_wake;                // Host touch in soft-down
    logic [7:0]       rdata_d;                  // Read mux

    assign mode      = mode_reg_q[spmm_pkg::MODE_LSB +: 2];
    assign soft_wake = (mode == spmm_pkg::MODE_SOFTPD) && (REG_WR_I || REG_RD_I);

    // Port address lookup
    function automatic logic [7:0] port_addr(input int i);
        case (i)
            0: port_addr = spmm_pkg::ADDR_PORT_CTL_A;
            1: port_addr = spmm_pkg::ADDR_PORT_CTL_B;
            2: port_addr = spmm_pkg::ADDR_PORT_CTL_C;
            default: port_addr = spmm_pkg::ADDR_PORT_CTL_D;
        endcase
    endfunction

    // Register writes and reads; a soft-down access restores defaults instead
    always_comb begin
        mode_reg_d = mode_reg_q;
        sleep_d    = sleep_q;
        pctl_d     = pctl_q;
        rdata_d    = 8'h00;
        if (soft_wake) begin
            mode_reg_d = spmm_pkg::RST_PWR_MODE;
            sleep_d    = spmm_pkg::RST_GO_SLEEP;
            for (int i = 0; i < NPORT; i++) pctl_d[i] = spmm_pkg::RST_PORT_CTL;
        end else if (REG_WR_I) begin
            // Writes of mode accepted in any mode but soft-down; leaving normal is the host's call
            if (REG_ADDR_I == spmm_pkg::ADDR_PWR_MODE) mode_reg_d = REG_WDATA_I;
            if (REG_ADDR_I == spmm_pkg::ADDR_GO_SLEEP) sleep_d = REG_WDATA_I;
            for (int i = 0; i < NPORT; i++)
                if (REG_ADDR_I == port_addr(i)) pctl_d[i] = REG_WDATA_I;
        end
        if (REG_RD_I && !soft_wake) begin
            if (REG_ADDR_I == spmm_pkg::ADDR_PWR_MODE) rdata_d = mode_reg_q;
            if (REG_ADDR_I == spmm_pkg::ADDR_GO_SLEEP) rdata_d = sleep_q;
            for (int i = 0; i < NPORT; i++)
                if (REG_ADDR_I == port_addr(i)) rdata_d = pctl_q[i];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_reg_q  <= spmm_pkg::RST_PWR_MODE;
            sleep_q     <= spmm_pkg::RST_GO_SLEEP;
            for (int i = 0; i < NPORT; i++) pctl_q[i] <= spmm_pkg::RST_PORT_CTL;
            REG_RDATA_O <= 8'h00;
        end else begin
            mode_reg_q  <= mode_reg_d;
            sleep_q     <= sleep_d;
            pctl_q      <= pctl_d;
            REG_RDATA_O <= rdata_d;
        end
    end

    // Energy-detect sub-state and quiet timer; timer counts units of go-sleep
    spmm_pkg::spmm_ed_t ed_q, ed_d;
    logic [31:0] unit_q, unit_d;   // Cycles within one unit
    logic [8:0]  quiet_q, quiet_d; // Whole units of quiet
    always_comb begin
        ed_d    = ed_q;
        unit_d  = unit_q;
        quiet_d = quiet_q;
        if (mode != spmm_pkg::MODE_EDETECT || energy) begin
            unit_d  = 32'h0000_0000;
            quiet_d = 9'h000;
            ed_d    = spmm_pkg::ED_AWAKE;
        end else begin
            case (ed_q)
                spmm_pkg::ED_AWAKE: begin
                    if (unit_q >= 32'(UNIT_CYC - 1)) begin
                        unit_d  = 32'h0000_0000;
                        quiet_d = quiet_q + 9'h001;
                    end else begin
                        unit_d = unit_q + 32'h0000_0001;
                    end
                    // Strictly longer than the programmed time
                    if (quiet_q > {1'b0, sleep_q}) ed_d = spmm_pkg::ED_ASLEEP;
                end
                spmm_pkg::ED_ASLEEP: ed_d = spmm_pkg::ED_ASLEEP;
                default: ed_d = spmm_pkg::ED_AWAKE;
            endcase
        end
    end
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ed_q    <= spmm_pkg::ED_AWAKE;
            unit_q  <= 32'h0000_0000;
            quiet_q <= 9'h000;
        end else begin
            ed_q    <= ed_d;
            unit_q  <= unit_d;
            quiet_q <= quiet_d;
        end
    end

    // One-second beacon in detect mode without a cable
    logic [31:0] bcn_q, bcn_d;
    logic        bcn_on;
    assign bcn_on = (mode == spmm_pkg::MODE_EDETECT) && !link_up;
    always_comb begin
        bcn_d = 32'h0000_0000;
        if (bcn_on) bcn_d = (bcn_q >= 32'(BEACON_CYC - 1)) ? 32'h0000_0000 : bcn_q + 32'h0000_0001;
    end

    // Block enables, a pure function of mode and sub-state, registered
    logic       asleep;
    logic [NPORT-1:0] pd_d;
    assign asleep = (mode == spmm_pkg::MODE_EDETECT) && (ed_q == spmm_pkg::ED_ASLEEP);
    always_comb begin
        for (int i = 0; i < NPORT; i++)
            pd_d[i] = pctl_q[i][spmm_pkg::PORT_PD_BIT] | MII_PD_I[i];
    end
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bcn_q       <= 32'h0000_0000;
            PLL_EN_O    <= 1'b1;
            PHY_EN_O    <= 1'b1;
            MAC_EN_O    <= 1'b1;
            HOST_EN_O   <= 1'b1;
            RX_DET_EN_O <= 1'b1;
            BEACON_O    <= 1'b0;
            PORT_PD_O   <= '0;
            INT_RST_O   <= 1'b0;
        end else begin
            bcn_q       <= bcn_d;
            // Normal and awake run everything; sleep keeps only receiver detect, soft-down drops all
            PLL_EN_O    <= !asleep && mode != spmm_pkg::MODE_SOFTPD;
            PHY_EN_O    <= !asleep && mode != spmm_pkg::MODE_SOFTPD;
            MAC_EN_O    <= !asleep && mode != spmm_pkg::MODE_SOFTPD;
            // Host stays able to decode a wake access in soft-down by strobe
            HOST_EN_O   <= !asleep && mode != spmm_pkg::MODE_SOFTPD;
            RX_DET_EN_O <= mode != spmm_pkg::MODE_SOFTPD;
            BEACON_O    <= bcn_on && (bcn_q < 32'(spmm_pkg::PULSE_CYC));
            PORT_PD_O   <= pd_d;
            INT_RST_O   <= soft_wake;
        end
    end

    // Checks
    property p_sleep_off;
        @(posedge CLK_I) disable iff (!RSTN_I) asleep |=> !PLL_EN_O && !MAC_EN_O && RX_DET_EN_O;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep left blocks on");
    property p_softpd;
        @(posedge CLK_I) disable iff (!RSTN_I)
            (mode == spmm_pkg::MODE_SOFTPD && !soft_wake) |=> !PLL_EN_O && !PHY_EN_O;
    endproperty
    a_softpd: assert property (p_softpd) else $error("soft-down left clocks on");
    property p_wake;
        @(posedge CLK_I) disable iff (!RSTN_I)
            soft_wake |=> INT_RST_O && mode == spmm_pkg::MODE_NORMAL && sleep_q == 8'h00;
    endproperty
    a_wake: assert property (p_wake) else $error("soft-down access did not reset");
    property p_normal;
        @(posedge CLK_I) disable iff (!RSTN_I)
            mode == spmm_pkg::MODE_NORMAL |=> PLL_EN_O && PHY_EN_O && MAC_EN_O && HOST_EN_O;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not fully on");
    property p_energy;
        @(posedge CLK_I) disable iff (!RSTN_I) energy |=> ed_q == spmm_pkg::ED_AWAKE;
    endproperty
    a_energy: assert property (p_energy) else $error("energy did not wake");
    property p_enter;
        @(posedge CLK_I) disable iff (!RSTN_I)
            (mode == spmm_pkg::MODE_EDETECT && !energy && ed_q == spmm_pkg::ED_AWAKE
             && quiet_q > {1'b0, sleep_q}) |=> ed_q == spmm_pkg::ED_ASLEEP;
    endproperty
    a_enter: assert property (p_enter) else $error("quiet time did not sleep");
    property p_early;
        @(posedge CLK_I) disable iff (!RSTN_I)
            (ed_q == spmm_pkg::ED_AWAKE && quiet_q <= {1'b0, sleep_q}) |=> ed_q == spmm_pkg::ED_AWAKE;
    endproperty
    a_early: assert property (p_early) else $error("slept too early");
    property p_pd;
        @(posedge CLK_I) disable iff (!RSTN_I) 1'b1 |=> PORT_PD_O == $past(pd_d);
    endproperty
    a_pd: assert property (p_pd) else $error("port power-down mismatch");
    // Beacon width counter for the check below; saturates so a stuck pin cannot wrap
    logic [7:0] bw_q, bw_d;
    always_comb begin
        bw_d = 8'h00;
        if (BEACON_O) bw_d = (bw_q == 8'hff) ? bw_q : bw_q + 8'h01;
    end
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bw_q <= 8'h00;
        end else begin
            bw_q <= bw_d;
        end
    end
    // A pulse cut short by a cable or mode change is not a width error
    property p_beacon;
        @(posedge CLK_I) disable iff (!RSTN_I)
            $fell(BEACON_O) && bcn_on |-> bw_q == 8'(spmm_pkg::PULSE_CYC);
    endproperty
    a_beacon: assert property (p_beacon) else $error("beacon width wrong");
endmodule
`default_nettype wire

// ### test/spmm_cable_model.sv
// Purpose: Cable and far-end partner seen by the power mode manager
// Assumes: Plug command changes only at the falling clock edge
// Notes:   Energy and attach levels follow the plug state; no noise modelled
`timescale 1ns/1ps
`default_nettype none
module spmm_cable_model (
    input  wire logic clk_i,     // Core clock
    input  wire logic plug_i,    // Cable plugged and partner active
    output logic      energy_o,  // Energy seen on the cable
    output logic      link_up_o  // Cable attached
);
    // Change levels off the sampling edge so the synchroniser sees clean steps
    always @(negedge clk_i) begin
        energy_o  <= plug_i;
        link_up_o <= plug_i;
    end
endmodule
`default_nettype wire

// ### test/test_spmm_top.sv
// Purpose: Self-checking bench for the power mode manager
// Assumes: Short beacon and sleep-unit parameters keep the run brief
// Notes:   Inputs move on the falling edge, outputs are sampled there too
`timescale 1ns/1ps
`default_nettype none
module test_spmm_top;
    logic       clk = 1'b0;            // Core clock
    logic       rstn = 1'b0;           // Reset, low active
    logic       wr = 1'b0;             // Write strobe
    logic       rd = 1'b0;             // Read strobe
    logic [7:0] addr = 8'h00;          // Register number
    logic [7:0] wdata = 8'h00;         // Write data
    logic [7:0] rdata;                 // Read data
    logic       plug = 1'b0;           // Cable plugged
    logic       energy;                // Cable energy
    logic       link_up;               // Cable attached
    logic [3:0] mii_pd = 4'h0;         // PHY control power-down bits
    logic       pll, phy, mac, host;   // Enables
    logic       rxdet, beacon, irst;   // Detect, line pulse, internal reset
    logic [3:0] port_pd;               // Per-port power-down
    int         n_fail = 0;            // Mismatches
    int         checks_done = 0;       // Comparisons
    int         n;                     // Wait counter
    localparam int T_BCN = 100;        // Short beacon period for simulation
    logic [7:0] regs [4] = '{spmm_pkg::ADDR_PORT_CTL_A, spmm_pkg::ADDR_PORT_CTL_B,
                             spmm_pkg::ADDR_PORT_CTL_C, spmm_pkg::ADDR_PORT_CTL_D};

    // Clock at 125 MHz
    initial begin
        forever #4 clk = ~clk;
    end

    spmm_top #(.NPORT(4), .BEACON_CYC(T_BCN), .UNIT_CYC(4)) i_spmm_top (
        .CLK_I(clk), .RSTN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .ENERGY_I(energy), .LINK_UP_I(link_up), .MII_PD_I(mii_pd),
        .PLL_EN_O(pll), .PHY_EN_O(phy), .MAC_EN_O(mac), .HOST_EN_O(host),
        .RX_DET_EN_O(rxdet), .BEACON_O(beacon), .PORT_PD_O(port_pd), .INT_RST_O(irst));

    spmm_cable_model i_spmm_cable_model (
        .clk_i(clk), .plug_i(plug), .energy_o(energy), .link_up_o(link_up));

    // Verdict in one place only
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask

    // A spent bound is a hang: count it and stop
    task automatic tmo(input int cnt, input int lim);
        if (cnt >= lim) begin
            chk(8'h01, 8'h00, "timeout");
            close_out();
        end
    endtask

    // One-cycle strobe accesses
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp, msg);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        // Defaults and enables after reset
        chk({4'h0, pll, phy, mac, host}, 8'h0f, "enables normal");
        rd_reg(spmm_pkg::ADDR_PWR_MODE, 8'h00, "mode reset");
        rd_reg(spmm_pkg::ADDR_GO_SLEEP, 8'h00, "go-sleep reset");
        rd_reg(8'h55, 8'h00, "unmapped");
        $display("test reset done");
        // Port power-down from both sources
        for (int i = 0; i < 4; i++) begin
            wr_reg(regs[i], (i % 2 == 0) ? 8'h08 : 8'h00);
            rd_reg(regs[i], (i % 2 == 0) ? 8'h08 : 8'h00, "port ctl");
        end
        mii_pd = 4'h2;
        repeat (2) @(negedge clk);
        chk({4'h0, port_pd}, 8'h07, "port power-down");
        mii_pd = 4'h0;
        $display("test port done");
        // Energy detect: sleep, beacon, wake
        wr_reg(spmm_pkg::ADDR_GO_SLEEP, 8'h02);
        wr_reg(spmm_pkg::ADDR_PWR_MODE, 8'h08);
        for (n = 0; n < 300 && beacon !== 1'b1; n++) @(negedge clk);
        tmo(n, 300);
        for (n = 0; n < 40 && beacon === 1'b1; n++) @(negedge clk);
        chk(8'(n), 8'(spmm_pkg::PULSE_CYC), "beacon width");
        // Low time up to the next pulse completes one beacon period
        for (n = 0; n < 200 && beacon !== 1'b1; n++) @(negedge clk);
        tmo(n, 200);
        chk(8'(n), 8'(T_BCN - spmm_pkg::PULSE_CYC), "beacon period");
        for (n = 0; n < 200 && pll !== 1'b0; n++) @(negedge clk);
        tmo(n, 200);
        chk({3'h0, pll, phy, mac, host, rxdet}, 8'h01, "asleep");
        plug = 1'b1;
        for (n = 0; n < 8 && pll !== 1'b1; n++) @(negedge clk);
        tmo(n, 8);
        @(negedge clk);
        chk({4'h0, pll, phy, mac, host}, 8'h0f, "awake");
        $display("test energy done");
        // Soft power-down and wake by access
        wr_reg(spmm_pkg::ADDR_PWR_MODE, 8'h10);
        repeat (2) @(negedge clk);
        chk({4'h0, pll, phy, mac, host}, 8'h00, "soft-down");
        rd_reg(spmm_pkg::ADDR_GO_SLEEP, 8'h00, "wake read");
        for (n = 0; n < 4 && irst !== 1'b1; n++) @(negedge clk);
        tmo(n, 4);
        chk({7'h00, irst}, 8'h01, "internal reset");
        repeat (2) @(negedge clk);
        chk({3'h0, irst, pll, phy, mac, host}, 8'h0f, "woken");
        rd_reg(spmm_pkg::ADDR_GO_SLEEP, 8'h00, "go-sleep cleared");
        rd_reg(spmm_pkg::ADDR_PORT_CTL_A, 8'h00, "port cleared");
        $display("test soft-down done");
        close_out();
    end
endmodule
`default_nettype wire
